// ===== hdl/tprc_buf.sv
// Two-entry character buffer with valid/ready on both sides
`timescale 1ns/100ps
module tprc_buf
  import tprc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [CHAR_W-1:0] in_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [CHAR_W-1:0]      out_data
);
  typedef struct packed {
    logic [1:0][CHAR_W-1:0] mem;
    logic                   rd_ptr;
    logic                   wr_ptr;
    logic [1:0]             count;
  } tprc_buf_s;

  tprc_buf_s st_reg;
  tprc_buf_s st_next;
  logic      push;
  logic      pop;

  assign in_ready  = (st_reg.count != 2'h2);
  assign out_valid = (st_reg.count != 2'h0);
  assign out_data  = st_reg.mem[st_reg.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr             = ~st_reg.wr_ptr;
    end
    if (pop) begin
      st_next.rd_ptr = ~st_reg.rd_ptr;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 2'h1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ===== hdl/tprc_pkg.sv
// Package of constants and types for the tape receiver punch control
package tprc_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned FEED_DELAY_US   = 725;
  localparam int unsigned FEED_DELAY_CYC  = (FEED_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 8;
  localparam logic [7:0]  CNT_RESET_VAL   = 8'h00;
  localparam logic [7:0]  CNT_FIRST_VAL   = 8'hff;
  localparam logic [7:0]  CNT_TERMINAL    = 8'h5f;
  localparam int unsigned CHAR_W          = 8;
  localparam int unsigned ALARM_INPUTS    = 7;
  localparam int unsigned PWR_DELAY_CYC   = 16;
  localparam int unsigned DLY_W           = 13;
  localparam int unsigned PWR_W           = 5;
  localparam logic [12:0] FEED_DELAY_CNT  = 13'(FEED_DELAY_CYC);
  localparam logic [4:0]  PWR_DELAY_CNT   = 5'(PWR_DELAY_CYC);

  typedef enum logic [1:0] {
    TPRC_SRC_NONE     = 2'b00,
    TPRC_SRC_PARALLEL = 2'b01,
    TPRC_SRC_SERIAL   = 2'b10
  } tprc_src_e;

  // Rising and falling edge of a synchronised level
  function automatic logic tprc_rise(input logic now_v, input logic old_v);
    return now_v & ~old_v;
  endfunction

  function automatic logic tprc_fall(input logic now_v, input logic old_v);
    return ~now_v & old_v;
  endfunction
endpackage

// ===== hdl/tprc_sync.sv
// Two-stage synchroniser with edge outputs
`timescale 1ns/100ps
module tprc_sync
  import tprc_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tprc_sync_s;

  tprc_sync_s st_reg;
  tprc_sync_s st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.s2;
  assign rise  = tprc_rise(st_reg.s2, st_reg.s3);
  assign fall  = tprc_fall(st_reg.s2, st_reg.s3);
endmodule

// ===== hdl/tprc_top.sv
// Punch source select, tape alarms and feed-fault counter of the tape receiver
//
// Summary of operation
// [R1] Parallel sample sets parallel mode
// [R2] Parallel character punched on sample falling edge
// [R3] Serial sample clears parallel mode
// [R4] Marking bits prime levels, spacing inhibits
// [R5] Serial character punched at sample end
// [R6] Supply-low only lights its lamp
// [R7] Supply exhausted cuts off the sender
// [R8] Exhausted and missing latches, own-button clear
// [R9] Loop-short latch holds after sensor release
// [R10] Waste-bin full only lights its lamp
// [R11] Eight-bit drive counter, reset by puller
// [R12] Feed fault before 161/162 pulses without puller; the code raises it on the 162nd drive fall
// [R13] Power-up holds reset then one pulse
// [R14] First pulse loads 255, then decrement
// [R15] Stage weights 1 through 128 binary
// [R16] Count 95 asserts terminal detector
// [R17] Next drive fall at terminal sets fault
// [R18] Puller latch cleared by 725us delay
// [R19] Combined button clears loop-short, restores feed
// [R20] Alarm relay held only when all inactive
// [R21] Seven alarm gate inputs
// [R22] Power off releases alarm relay
// [R23] Busy-out toggle marks out of service
// [R24] Inputs synchronised and edge-detected; power_ok, blank_feed and char_feed are used unsynchronised
`timescale 1ns/100ps
module tprc_top
  import tprc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              power_ok,
  input  wire logic              par_sample,
  input  wire logic [CHAR_W-1:0] par_bits,
  input  wire logic              ser_sample,
  input  wire logic [CHAR_W-1:0] ser_bits,
  input  wire logic              drive_pulse,
  input  wire logic              puller_pulse,
  input  wire logic              blank_feed,
  input  wire logic              char_feed,
  input  wire logic              busy_button,
  input  wire logic              supply_low_sw,
  input  wire logic              supply_exh_sw,
  input  wire logic              tape_missing_sw,
  input  wire logic              loop_short_sw,
  input  wire logic              waste_full_sw,
  input  wire logic              exh_clear_button,
  input  wire logic              missing_clear_button,
  input  wire logic              loop_feed_button,
  output logic                   punch_valid,
  input  wire logic              punch_ready,
  output logic [CHAR_W-1:0]      punch_data,
  output logic                   parallel_mode,
  output logic                   serial_mode,
  output logic                   supply_low_lamp,
  output logic                   waste_full_lamp,
  output logic                   supply_exhausted_alarm,
  output logic                   tape_missing_lamp,
  output logic                   loop_short_alarm,
  output logic                   feed_fault_lamp,
  output logic                   busy_lamp,
  output logic                   sender_cutoff,
  output logic                   alarm_relay,
  output logic [CNT_W-1:0]       feed_count,
  output logic                   char_overrun
);
  // ==========================================================
  // Input synchronisers
  // ==========================================================
  localparam int unsigned NSYNC = 12;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] lvl;
  logic [NSYNC-1:0] rise;
  logic [NSYNC-1:0] fall;

  assign raw_in = {loop_feed_button, missing_clear_button, exh_clear_button, waste_full_sw,
                   loop_short_sw, tape_missing_sw, supply_exh_sw, busy_button,
                   puller_pulse, drive_pulse, ser_sample, par_sample};

  // [R24] Synchronise the twelve edge-detected inputs
  for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
    tprc_sync u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .din    (raw_in[gi]),
      .level  (lvl[gi]),
      .rise   (rise[gi]),
      .fall   (fall[gi])
    );
  end

  // Index names of synchronised inputs
  localparam int unsigned I_PAR   = 0;
  localparam int unsigned I_SER   = 1;
  localparam int unsigned I_DRV   = 2;
  localparam int unsigned I_PULL  = 3;
  localparam int unsigned I_BUSY  = 4;
  localparam int unsigned I_EXH   = 5;
  localparam int unsigned I_MISS  = 6;
  localparam int unsigned I_LOOP  = 7;
  localparam int unsigned I_WASTE = 8;
  localparam int unsigned I_EXHC  = 9;
  localparam int unsigned I_MISSC = 10;
  localparam int unsigned I_LOOPF = 11;

  // Character data delayed to match synchroniser latency
  logic [CHAR_W-1:0] par_d1;
  logic [CHAR_W-1:0] par_d2;
  logic [CHAR_W-1:0] ser_d1;
  logic [CHAR_W-1:0] ser_d2;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      par_d1 <= '0;
      par_d2 <= '0;
      ser_d1 <= '0;
      ser_d2 <= '0;
    end else begin
      par_d1 <= par_bits;
      par_d2 <= par_d1;
      ser_d1 <= ser_bits;
      ser_d2 <= ser_d1;
    end
  end

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    tprc_src_e          src;
    logic               powered;
    logic [PWR_W-1:0]   pwr_cnt;
    logic               exh_latch;
    logic               miss_latch;
    logic               loop_latch;
    logic               feed_ok;
    logic               busy;
    logic               puller_latch;
    logic               cnt_loaded;
    logic [CNT_W-1:0]   cnt;
    logic               dly_run;
    logic [DLY_W-1:0]   dly_cnt;
    logic               overrun;
  } tprc_top_s;

  tprc_top_s         st_reg;
  tprc_top_s         st_next;
  logic              char_valid;
  logic              char_ready;
  logic [CHAR_W-1:0] char_data;
  logic              terminal;
  logic              cnt_clear;
  logic              feeding;

  assign feeding  = blank_feed | char_feed;
  // [R16] Terminal detector at 95
  assign terminal = st_reg.cnt_loaded & (st_reg.cnt == CNT_TERMINAL);

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    st_next    = st_reg;
    char_valid = 1'b0;
    char_data  = '0;
    cnt_clear  = 1'b0;

    // Counter held clear and capture blocked until powered
    // [R13] Power-on hold then release pulse
    if (!st_reg.powered) begin
      if (st_reg.pwr_cnt == PWR_DELAY_CNT) begin
        st_next.powered = 1'b1;
        cnt_clear       = 1'b1;
      end else begin
        st_next.pwr_cnt = st_reg.pwr_cnt + 5'h01;
      end
    end

    // [R1] Parallel sample selects parallel path
    if (rise[I_PAR]) begin
      st_next.src = TPRC_SRC_PARALLEL;
    end
    // [R3] Serial sample selects serial path
    if (rise[I_SER]) begin
      st_next.src = TPRC_SRC_SERIAL;
    end

    // Feeding and power-up block external data
    if (st_reg.powered && !feeding) begin
      // [R2] Punch parallel character on falling edge
      if (fall[I_PAR] && st_reg.src == TPRC_SRC_PARALLEL) begin
        char_valid = 1'b1;
        char_data  = par_d2;
      // [R5] Punch serial character at pulse end
      end else if (fall[I_SER] && st_reg.src == TPRC_SRC_SERIAL) begin
        char_valid = 1'b1;
        // [R4] Marking primes, spacing inhibits
        char_data  = ser_d2;
      end
    end
    if (char_valid && !char_ready) begin
      st_next.overrun = 1'b1;
    end

    // [R8] Exhausted and missing latches
    if (lvl[I_EXH]) begin
      st_next.exh_latch = 1'b1;
    end else if (rise[I_EXHC]) begin
      st_next.exh_latch = 1'b0;
    end
    if (lvl[I_MISS]) begin
      st_next.miss_latch = 1'b1;
    end else if (rise[I_MISSC]) begin
      st_next.miss_latch = 1'b0;
    end

    // [R9] Loop-short latch holds
    if (lvl[I_LOOP]) begin
      st_next.loop_latch = 1'b1;
    // [R19] Combined button clears or restores
    end else if (rise[I_LOOPF] && st_reg.loop_latch) begin
      st_next.loop_latch = 1'b0;
    end else if (rise[I_LOOPF] && !st_reg.feed_ok) begin
      st_next.feed_ok = 1'b1;
    end

    // [R23] Busy-out push toggle
    if (rise[I_BUSY]) begin
      st_next.busy = ~st_reg.busy;
    end

    // [R18] Puller pulses caught in a latch
    if (lvl[I_PULL]) begin
      st_next.puller_latch = 1'b1;
    end

    // [R18] Delay started by drive fall
    if (st_reg.dly_run) begin
      if (st_reg.dly_cnt == FEED_DELAY_CNT - 13'h0001) begin
        st_next.dly_run = 1'b0;
        if (st_reg.puller_latch) begin
          st_next.puller_latch = lvl[I_PULL];
          cnt_clear            = 1'b1;
        end
      end else begin
        st_next.dly_cnt = st_reg.dly_cnt + 13'h0001;
      end
    end

    // [R11] Count drive pulses
    if (fall[I_DRV] && st_reg.powered) begin
      st_next.dly_run = 1'b1;
      st_next.dly_cnt = '0;
      // [R17] Terminal plus drive fall clears feed flip-flop
      if (terminal) begin
        st_next.feed_ok = 1'b0;
      end
      // [R14] First pulse loads full count
      if (!st_reg.cnt_loaded) begin
        st_next.cnt_loaded = 1'b1;
        st_next.cnt        = CNT_FIRST_VAL;
      // [R15] Binary-weighted decrement
      end else if (st_reg.cnt != CNT_RESET_VAL) begin
        st_next.cnt = st_reg.cnt - 8'h01;
      end
    end

    // [R12] Puller reset keeps count short of fault
    if (cnt_clear || !st_reg.powered) begin
      st_next.cnt        = CNT_RESET_VAL;
      st_next.cnt_loaded = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg         <= '0;
      st_reg.src     <= TPRC_SRC_NONE;
      st_reg.feed_ok <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Supply-low lamp
  // ==========================================================
  // Lamp path only: never reaches capture or the alarm gate
  logic supply_low_q;
  logic supply_low_s1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_low_s1 <= 1'b0;
      supply_low_q  <= 1'b0;
    end else begin
      supply_low_s1 <= supply_low_sw;
      supply_low_q  <= supply_low_s1;
    end
  end

  // ==========================================================
  // Punch character buffer
  // ==========================================================
  tprc_buf u_buf (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (char_valid),
    .in_ready  (char_ready),
    .in_data   (char_data),
    .out_valid (punch_valid),
    .out_ready (punch_ready),
    .out_data  (punch_data)
  );

  // ==========================================================
  // Outputs
  // ==========================================================
  assign parallel_mode = (st_reg.src == TPRC_SRC_PARALLEL);
  assign serial_mode   = (st_reg.src == TPRC_SRC_SERIAL);
  // [R6] Supply-low lamp only
  assign supply_low_lamp        = supply_low_q;
  // [R10] Waste-bin lamp only
  assign waste_full_lamp        = lvl[I_WASTE];
  assign supply_exhausted_alarm = st_reg.exh_latch;
  assign tape_missing_lamp      = st_reg.miss_latch;
  assign loop_short_alarm       = st_reg.loop_latch;
  assign feed_fault_lamp        = ~st_reg.feed_ok;
  assign busy_lamp              = st_reg.busy;
  // [R7] Exhausted supply stops the sender
  assign sender_cutoff          = st_reg.exh_latch;
  assign feed_count             = st_reg.cnt;
  assign char_overrun           = st_reg.overrun;

  // ==========================================================
  // Alarm gate
  // ==========================================================
  // Relay is held for no alarm, so loss of power reads as alarm
  // [R21] Seven-input alarm gate
  logic [ALARM_INPUTS-1:0] alarm_in;
  assign alarm_in = {blank_feed, char_feed, st_reg.busy, st_reg.exh_latch,
                     st_reg.miss_latch, st_reg.loop_latch, ~st_reg.feed_ok};
  // [R20] [R22] Relay held only when powered and clear
  assign alarm_relay = power_ok & st_reg.powered & ~(|alarm_in);
endmodule

// ===== test/tb.sv
// Self-checking bench for the tape receiver punch control
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb
  import tprc_pkg::*;
;
  logic              clk, arst_n, power_ok, par_sample, ser_sample, blank_feed, char_feed, stall;
  logic [CHAR_W-1:0] par_bits, ser_bits, punch_data;
  logic [5:0]        btn;
  logic [4:0]        sw;
  logic              punch_valid, punch_ready, parallel_mode, serial_mode, supply_low_lamp, waste_full_lamp;
  logic              supply_exhausted_alarm, tape_missing_lamp, loop_short_alarm, feed_fault_lamp, busy_lamp;
  logic              sender_cutoff, alarm_relay, char_overrun;
  logic [CNT_W-1:0]  feed_count;
  logic [7:0]        got;
  int                bad_count, checked;
  // Power, blank, char, sensors, then supply-low lamp, waste lamp, relay
  logic [10:0]       rows [6] = '{11'h401, 11'h40d, 11'h483, 11'h000, 11'h60c, 11'h582};

  tprc_top dut (
    .busy_button(btn[0]), .exh_clear_button(btn[1]), .missing_clear_button(btn[2]),
    .loop_feed_button(btn[3]), .drive_pulse(btn[4]), .puller_pulse(btn[5]),
    .supply_low_sw(sw[0]), .supply_exh_sw(sw[1]), .tape_missing_sw(sw[2]),
    .loop_short_sw(sw[3]), .waste_full_sw(sw[4]), .*
  );
  tprc_punch_model pm (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #10;
    end
  endtask

  task automatic pulse(input int i);
    btn[i] = 1'b1;
    tick(4);
    btn[i] = 1'b0;
    tick(4);
  endtask

  // One sample pulse per character, lead left low after
  task automatic send(input logic ser, input logic [7:0] d);
    par_bits = ser ? ~d : d;
    ser_bits = ser ? d : ~d;
    {ser_sample, par_sample} = ser ? 2'b10 : 2'b01;
    tick(4);
    {ser_sample, par_sample} = 2'b00;
    tick(6);
  endtask

  task automatic test_end(input string s);
    $display("test %s done", s);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #3_000_000;
    bad_count++;
    complete_run();
  end

  initial begin
    {arst_n, par_sample, ser_sample, blank_feed, char_feed, stall} = 6'h00;
    {power_ok, par_bits, ser_bits, btn, sw} = {1'b1, 27'h0000000};
    tick(16);
    `CHK({feed_count, alarm_relay}, 9'h000)
    arst_n = 1'b1;
    tick(4);
    `CHK(feed_count, CNT_RESET_VAL)
    tick(30);
    test_end("reset");
    for (int i = 0; i < 6; i++) begin
      {power_ok, blank_feed, char_feed, sw} = rows[i][10:3];
      tick(4);
      `CHK({supply_low_lamp, waste_full_lamp, alarm_relay}, rows[i][2:0])
    end
    {power_ok, blank_feed, char_feed, sw} = 8'h80;
    tick(30);
    test_end("table");
    sw[1] = 1'b1;
    tick(4);
    `CHK({supply_exhausted_alarm, sender_cutoff, alarm_relay}, 3'b110)
    sw[1] = 1'b0;
    pulse(2);
    `CHK(supply_exhausted_alarm, 1'b1)
    pulse(1);
    `CHK({supply_exhausted_alarm, sender_cutoff}, 2'b00)
    sw[2] = 1'b1;
    tick(4);
    sw[2] = 1'b0;
    pulse(1);
    `CHK(tape_missing_lamp, 1'b1)
    pulse(2);
    `CHK(tape_missing_lamp, 1'b0)
    sw[3] = 1'b1;
    tick(4);
    sw[3] = 1'b0;
    tick(4);
    `CHK({loop_short_alarm, alarm_relay}, 2'b10)
    pulse(3);
    `CHK(loop_short_alarm, 1'b0)
    pulse(0);
    `CHK({busy_lamp, alarm_relay}, 2'b10)
    pulse(0);
    `CHK({busy_lamp, alarm_relay}, 2'b01)
    test_end("latches");
    send(1'b0, 8'ha5);
    `CHK({parallel_mode, serial_mode, got, pm.mem[0]}, {2'b10, 8'h01, 8'ha5})
    send(1'b1, 8'h3c);
    `CHK({parallel_mode, serial_mode, pm.mem[1]}, {2'b01, 8'h3c})
    stall = 1'b1;
    send(1'b1, 8'h81);
    send(1'b1, 8'h42);
    send(1'b1, 8'h99);
    `CHK({punch_valid, char_overrun, got}, {2'b11, 8'h02})
    stall = 1'b0;
    tick(4);
    `CHK({got, pm.mem[2], pm.mem[3]}, {8'h04, 8'h81, 8'h42})
    test_end("punch");
    pulse(4);
    `CHK(feed_count, CNT_FIRST_VAL)
    pulse(4);
    `CHK(feed_count, 8'hfe)
    repeat (158) pulse(4);
    `CHK(feed_count, 8'h60)
    pulse(4);
    `CHK({feed_count, feed_fault_lamp}, {CNT_TERMINAL, 1'b0})
    pulse(4);
    `CHK({feed_fault_lamp, alarm_relay}, 2'b10)
    pulse(3);
    `CHK({feed_fault_lamp, alarm_relay}, 2'b01)
    test_end("counter");
    tick(7300);
    pulse(5);
    pulse(4);
    tick(7200);
    `CHK(feed_count == CNT_RESET_VAL, 1'b0)
    tick(100);
    `CHK(feed_count, CNT_RESET_VAL)
    pulse(4);
    `CHK(feed_count, CNT_FIRST_VAL)
    test_end("puller");
    complete_run();
  end
endmodule

// ===== test/tprc_chk.sv
// Port assertions for the tape receiver punch control
`timescale 1ns/100ps
module tprc_chk
  import tprc_pkg::*;
(
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              power_ok,
  input wire logic              blank_feed,
  input wire logic              char_feed,
  input wire logic              supply_exh_sw,
  input wire logic              exh_clear_button,
  input wire logic              loop_feed_button,
  input wire logic              punch_valid,
  input wire logic              punch_ready,
  input wire logic [CHAR_W-1:0] punch_data,
  input wire logic              parallel_mode,
  input wire logic              serial_mode,
  input wire logic              supply_exhausted_alarm,
  input wire logic              tape_missing_lamp,
  input wire logic              loop_short_alarm,
  input wire logic              feed_fault_lamp,
  input wire logic              busy_lamp,
  input wire logic              sender_cutoff,
  input wire logic              alarm_relay,
  input wire logic [CNT_W-1:0]  feed_count,
  input wire logic              char_overrun
);
  logic [5:0] up_reg;
  logic       any_latch;

  assign any_latch = supply_exhausted_alarm | tape_missing_lamp | loop_short_alarm
                   | feed_fault_lamp | busy_lamp;

  // Cycles since reset release with power present, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_reg <= 6'h00;
    end else begin
      up_reg <= !power_ok ? 6'h00 : (up_reg == 6'h3f ? up_reg : up_reg + 6'h01);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_power_off_alarm: assert property (!power_ok |-> !alarm_relay)
    else $error("relay held without power");
  a_feeding_alarm: assert property (blank_feed || char_feed |-> !alarm_relay)
    else $error("relay held while feeding");
  a_latch_alarm: assert property (any_latch |-> !alarm_relay)
    else $error("relay held with an alarm latch set");
  a_relay_quiet: assert property (
    up_reg == 6'h3f && power_ok && !blank_feed && !char_feed && !any_latch |-> alarm_relay)
    else $error("relay released with no alarm");
  a_exh_cutoff: assert property (
    (up_reg == 6'h3f) ##0 supply_exh_sw [*3] |-> ##[0:2] (sender_cutoff && supply_exhausted_alarm))
    else $error("exhausted sensor did not cut off sender");
  a_exh_hold: assert property (
    supply_exhausted_alarm && !exh_clear_button && !$past(exh_clear_button)
    && !$past(exh_clear_button, 2) && !$past(exh_clear_button, 3) |=> supply_exhausted_alarm)
    else $error("exhausted latch dropped without its button");
  a_loop_hold: assert property (
    loop_short_alarm && !loop_feed_button && !$past(loop_feed_button)
    && !$past(loop_feed_button, 2) && !$past(loop_feed_button, 3) |=> loop_short_alarm)
    else $error("loop-short latch dropped without button");
  a_count_step: assert property (
    feed_count != $past(feed_count) |-> feed_count == $past(feed_count) - 8'h01
    || feed_count == CNT_FIRST_VAL || feed_count == CNT_RESET_VAL)
    else $error("feed count moved by an illegal step");
  a_mode_excl: assert property (!(parallel_mode && serial_mode))
    else $error("both punch sources selected");
  a_out_hold: assert property (punch_valid && !punch_ready |=> punch_valid && $stable(punch_data))
    else $error("punch character changed while stalled");

  c_fault: cover property ($rose(feed_fault_lamp));
  c_par_char: cover property (punch_valid && punch_ready && parallel_mode);
  c_overrun: cover property ($rose(char_overrun));
endmodule

bind tprc_top tprc_chk u_chk (.*);

// ===== test/tprc_punch_model.sv
// Punch mechanism model taking characters from the punch port
`timescale 1ns/100ps
module tprc_punch_model
  import tprc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              stall,
  input  wire logic              punch_valid,
  output logic                   punch_ready,
  input  wire logic [CHAR_W-1:0] punch_data,
  output logic [7:0]             got
);
  logic [CHAR_W-1:0] mem [8];

  assign punch_ready = ~stall;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      got <= 8'h00;
    end else if (punch_valid && punch_ready) begin
      mem[got[2:0]] <= punch_data;
      got <= got + 8'h01;
    end
  end
endmodule
